// *** include/tcsirq_pkg.sv ***
// Package with register map, field layout and reset values of the channel status/interrupt block
package tcsirq_pkg;

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] STATUS_OFF     = 8'h20;
  localparam logic [7:0] EN_SET_OFF     = 8'h24;
  localparam logic [7:0] EN_CLR_OFF     = 8'h28;
  localparam logic [7:0] EN_VIEW_OFF    = 8'h2c;
  localparam logic [7:0] CMP_C_OFF      = 8'h1c;

  // ----------------------------------------
  // Status word field positions
  // ----------------------------------------
  localparam int EVT_COUNT      = 8;
  localparam int OVF_BIT        = 0;
  localparam int OVRUN_BIT      = 1;
  localparam int MATCH_A_BIT    = 2;
  localparam int MATCH_B_BIT    = 3;
  localparam int MATCH_C_BIT    = 4;
  localparam int LOAD_A_BIT     = 5;
  localparam int LOAD_B_BIT     = 6;
  localparam int TRIG_BIT       = 7;
  localparam int CLK_ON_BIT     = 16;
  localparam int LINE_A_BIT     = 17;
  localparam int LINE_B_BIT     = 18;

  // ----------------------------------------
  // Mode select encoding and reset values
  // ----------------------------------------
  localparam logic MODE_CAPTURE  = 1'b0;
  localparam logic MODE_WAVEFORM = 1'b1;
  localparam logic [7:0]  FLAGS_RST  = 8'h00;
  localparam logic [7:0]  ENABLE_RST = 8'h00;
  localparam logic [31:0] RDATA_RST  = 32'h0000_0000;
  localparam logic [15:0] CMP_C_RST  = 16'h0000;

endpackage : tcsirq_pkg

// *** include/tcsirq_evt_if.sv ***
// Interface carrying raw event strobes from the top module to the flag keeper
`timescale 1ns/10ps
interface tcsirq_evt_if;
  logic [7:0] evtRaw;
  logic       statusRead;
  logic [7:0] flags;

  modport src
  (
    output evtRaw,
    output statusRead,
    input  flags
  );
  modport keeper
  (
    input  evtRaw,
    input  statusRead,
    output flags
  );
endinterface : tcsirq_evt_if

// *** verilog/tcsirq_flags.sv ***
// Sticky event flags, cleared by a status read
`timescale 1ns/10ps
module tcsirq_flags
(
  input wire logic        clk_sys,
  input wire logic        nrst,
  tcsirq_evt_if.keeper    evt
);

  logic [7:0] flags_reg;

  // ----------------------------------------
  // One sticky bit per event; set beats clear
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < tcsirq_pkg::EVT_COUNT; i++)
    begin : g_flag
      always_ff @(posedge clk_sys or negedge nrst)
      begin
        if (!nrst)
          flags_reg[i] <= tcsirq_pkg::FLAGS_RST[i];
        else if (evt.evtRaw[i])
          flags_reg[i] <= 1'b1; // R18
        else if (evt.statusRead)
          flags_reg[i] <= 1'b0;
      end
    end
  endgenerate

  assign evt.flags = flags_reg;

endmodule : tcsirq_flags

// *** verilog/tcsirq_top.sv ***
// Timer channel status and interrupt control with register port
//
// Contract
// [R1] Overflow sets status bit 0; status read clears it.
// [R2] Capture mode: second unread load of A or B sets bit 1.
// [R3] Waveform mode: compare A match sets bit 2; read clears.
// [R4] Waveform mode: compare B match sets bit 3; read clears.
// [R5] Any mode: compare C match sets bit 4; read clears.
// [R6] Capture mode: load of capture A sets bit 5; read clears.
// [R7] Capture mode: load of capture B sets bit 6; read clears.
// [R8] External trigger sets bit 7; read clears.
// [R9] Bit 16 shows live counter clock enable, not cleared by read.
// [R10] Bit 17 mirrors line A: pin in capture, driven level in waveform.
// [R11] Bit 18 mirrors line B: pin in capture, driven level in waveform.
// [R12] Enable-set write sets enables where data bits are one.
// [R13] Enable-clear write clears enables where data bits are one.
// [R14] Enable view read returns the eight current enables.
// [R15] Compare C read returns its live value.
// [R16] Mode select zero is capture, one is waveform.
// [R17] Interrupt high while any enabled flag is set.
// [R18] Event in the same cycle as status read keeps its flag.
//
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/10ps
module tcsirq_top
#(
  parameter int CNT_WIDTH = 16
)
(
  input  wire logic                 clk_sys,
  input  wire logic                 nrst,
  input  wire logic [7:0]           regAddr,
  input  wire logic [31:0]          regWdata,
  input  wire logic                 regWrite,
  input  wire logic                 regRead,
  output logic      [31:0]          regRdata,
  output logic                      irq,
  input  wire logic                 modeWave,
  input  wire logic                 ovfPulse,
  input  wire logic                 matchAPulse,
  input  wire logic                 matchBPulse,
  input  wire logic                 matchCPulse,
  input  wire logic                 loadAPulse,
  input  wire logic                 loadBPulse,
  input  wire logic                 readAPulse,
  input  wire logic                 readBPulse,
  input  wire logic                 trigPulse,
  input  wire logic                 counterClockOn,
  input  wire logic                 channelLineAPin,
  input  wire logic                 channelLineBPin,
  input  wire logic                 channelLineADrive,
  input  wire logic                 channelLineBDrive,
  input  wire logic [CNT_WIDTH-1:0] compareRegC
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  tcsirq_evt_if evt ();
  logic [7:0]  enable_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        pendA_reg;
  logic        pendB_reg;
  logic        captureMode;
  logic        ovrunEvt;
  logic [7:0]  evtRaw;
  logic [31:0] statusWord;

  // Mode decode
  assign captureMode = (modeWave == tcsirq_pkg::MODE_CAPTURE); // R16

  // ----------------------------------------
  // Load overrun tracking
  // ----------------------------------------
  // Capture A holds an unread value
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      pendA_reg <= 1'b0;
    else if (!captureMode)
      pendA_reg <= 1'b0;
    else if (loadAPulse)
      pendA_reg <= 1'b1;
    else if (readAPulse)
      pendA_reg <= 1'b0;
  end

  // Capture B holds an unread value
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      pendB_reg <= 1'b0;
    else if (!captureMode)
      pendB_reg <= 1'b0;
    else if (loadBPulse)
      pendB_reg <= 1'b1;
    else if (readBPulse)
      pendB_reg <= 1'b0;
  end

  // Second load while the previous one is unread
  assign ovrunEvt = captureMode &&
                    ((loadAPulse && pendA_reg) || (loadBPulse && pendB_reg)); // R2

  // ----------------------------------------
  // Mode-qualified event strobes
  // ----------------------------------------
  always_comb
  begin
    evtRaw = 8'h00;
    evtRaw[tcsirq_pkg::OVF_BIT]     = ovfPulse; // R1
    evtRaw[tcsirq_pkg::OVRUN_BIT]   = ovrunEvt; // R2
    evtRaw[tcsirq_pkg::MATCH_A_BIT] = matchAPulse && !captureMode; // R3
    evtRaw[tcsirq_pkg::MATCH_B_BIT] = matchBPulse && !captureMode; // R4
    evtRaw[tcsirq_pkg::MATCH_C_BIT] = matchCPulse; // R5
    evtRaw[tcsirq_pkg::LOAD_A_BIT]  = loadAPulse && captureMode; // R6
    evtRaw[tcsirq_pkg::LOAD_B_BIT]  = loadBPulse && captureMode; // R7
    evtRaw[tcsirq_pkg::TRIG_BIT]    = trigPulse; // R8
  end

  assign evt.evtRaw     = evtRaw;
  assign evt.statusRead = regRead && (regAddr == tcsirq_pkg::STATUS_OFF); // R1

  // Sticky flag keeper
  tcsirq_flags u_flags
  (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .evt     (evt)
  );

  // ----------------------------------------
  // Interrupt enables
  // ----------------------------------------
  // Set, then clear, by written ones
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      enable_reg <= tcsirq_pkg::ENABLE_RST;
    else if (regWrite && regAddr == tcsirq_pkg::EN_SET_OFF)
      enable_reg <= enable_reg | regWdata[7:0]; // R12
    else if (regWrite && regAddr == tcsirq_pkg::EN_CLR_OFF)
      enable_reg <= enable_reg & ~regWdata[7:0]; // R13
  end

  // Level interrupt from enabled flags
  assign irq = |(evt.flags & enable_reg); // R17

  // ----------------------------------------
  // Status word assembly
  // ----------------------------------------
  always_comb
  begin
    statusWord = 32'h0000_0000;
    statusWord[7:0] = evt.flags;
    statusWord[tcsirq_pkg::CLK_ON_BIT] = counterClockOn; // R9
    statusWord[tcsirq_pkg::LINE_A_BIT] = captureMode ? channelLineAPin : channelLineADrive; // R10
    statusWord[tcsirq_pkg::LINE_B_BIT] = captureMode ? channelLineBPin : channelLineBDrive; // R11
  end

  // ----------------------------------------
  // Read data mux
  // ----------------------------------------
  always_comb
  begin
    rdata_next = 32'h0000_0000;
    if (regRead)
    begin
      unique case (regAddr)
        tcsirq_pkg::STATUS_OFF:  rdata_next = statusWord;
        tcsirq_pkg::EN_VIEW_OFF: rdata_next = {24'h000000, enable_reg}; // R14
        tcsirq_pkg::CMP_C_OFF:   rdata_next = 32'(compareRegC); // R15
        default:                 rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // Read data register, valid the cycle after the strobe
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      rdata_reg <= tcsirq_pkg::RDATA_RST;
    else
      rdata_reg <= rdata_next;
  end

  assign regRdata = rdata_reg;

endmodule : tcsirq_top

// *** tb/tcsirq_chk.sv ***
// Concurrent checks on the status and interrupt block ports
`timescale 1ns/10ps
module tcsirq_chk
#(
  parameter int CNT_WIDTH = 16
)
(
  input wire logic                 clk_sys,
  input wire logic                 nrst,
  input wire logic [7:0]           regAddr,
  input wire logic [31:0]          regWdata,
  input wire logic                 regWrite,
  input wire logic                 regRead,
  input wire logic [31:0]          regRdata,
  input wire logic                 irq,
  input wire logic                 modeWave,
  input wire logic                 ovfPulse,
  input wire logic                 counterClockOn,
  input wire logic                 channelLineAPin,
  input wire logic                 channelLineBPin,
  input wire logic                 channelLineADrive,
  input wire logic                 channelLineBDrive,
  input wire logic [CNT_WIDTH-1:0] compareRegC
);
  // ----------------------------------------
  // Status read decode and clocking
  // ----------------------------------------
  wire rdStat = regRead && regAddr == tcsirq_pkg::STATUS_OFF;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_ovf_set: assert property ((ovfPulse ##1 !rdStat ##1 rdStat) |=> regRdata[0])
    else $error("overflow flag missing");
  a_ovf_clear: assert property ((rdStat && !ovfPulse ##1 !ovfPulse ##1 rdStat) |=> !regRdata[0])
    else $error("overflow flag not cleared by read");
  a_capture_quiet: assert property ((rdStat && !modeWave ##1 !modeWave ##1 rdStat && !modeWave)
    |=> regRdata[3:2] == 2'b00)
    else $error("compare flags set in capture mode");
  a_wave_quiet: assert property ((rdStat && modeWave ##1 modeWave ##1 rdStat && modeWave)
    |=> regRdata[6:5] == 2'b00 && !regRdata[1])
    else $error("load flags set in waveform mode");
  a_live_bits: assert property (rdStat |=> regRdata[18:16] == $past({modeWave ? channelLineBDrive : channelLineBPin,
    modeWave ? channelLineADrive : channelLineAPin, counterClockOn}))
    else $error("live status bits wrong");
  a_cmpc_read: assert property ((regRead && regAddr == tcsirq_pkg::CMP_C_OFF)
    |=> regRdata == 32'($past(compareRegC)))
    else $error("compare C read wrong");
  a_rdata_idle: assert property (!regRead |=> regRdata == 32'h0000_0000)
    else $error("read data not zero outside read");
  a_irq_off: assert property ((regWrite && regAddr == tcsirq_pkg::EN_CLR_OFF && regWdata[7:0] == 8'hff)
    |=> !irq)
    else $error("interrupt high with all enables cleared");
  a_wo_read: assert property ((regRead && regAddr == tcsirq_pkg::EN_SET_OFF) |=> regRdata == 32'h0000_0000)
    else $error("write-only register read not zero");
endmodule : tcsirq_chk

bind tcsirq_top tcsirq_chk #(.CNT_WIDTH(CNT_WIDTH)) u_chk
(
  .clk_sys, .nrst, .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .irq, .modeWave, .ovfPulse,
  .counterClockOn, .channelLineAPin, .channelLineBPin, .channelLineADrive, .channelLineBDrive, .compareRegC
);

// *** tb/tb.sv ***
// Register-level test of the status and interrupt block
`timescale 1ns/10ps
module tb;
  logic        clk_sys, nrst, regWrite, regRead, modeWave, counterClockOn, irq;
  logic        channelLineAPin, channelLineBPin, channelLineADrive, channelLineBDrive;
  logic [7:0]  regAddr;
  logic [31:0] regWdata, regRdata;
  logic [8:0]  ev;
  logic [15:0] compareRegC;
  int          mismatches = 0, n_compared = 0, cycles = 0;

  tcsirq_top #(.CNT_WIDTH(16)) dut
  (
    .clk_sys, .nrst, .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .irq, .modeWave,
    .ovfPulse(ev[0]), .readAPulse(ev[1]), .matchAPulse(ev[2]), .matchBPulse(ev[3]), .matchCPulse(ev[4]),
    .loadAPulse(ev[5]), .loadBPulse(ev[6]), .trigPulse(ev[7]), .readBPulse(ev[8]), .counterClockOn,
    .channelLineAPin, .channelLineBPin, .channelLineADrive, .channelLineBDrive, .compareRegC
  );

  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // One-cycle write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk_sys);
    regWrite <= 1'b0;
    #1;
  endtask : wr

  // One-cycle read, optional events in the same cycle
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [8:0] m = 9'h000);
    @(posedge clk_sys);
    regRead <= 1'b1;
    regAddr <= a;
    ev <= m;
    @(posedge clk_sys);
    regRead <= 1'b0;
    ev <= 9'h000;
    #1 chk(regRdata, e);
  endtask : rd

  // One-cycle event strobes
  task automatic pulse(input logic [8:0] m);
    @(posedge clk_sys);
    ev <= m;
    @(posedge clk_sys);
    ev <= 9'h000;
    #1;
  endtask : pulse

  // Counts and verdict
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  // Clock
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // Hang guard
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      mismatches++;
      finish_test();
    end
  end

  // Main sequence
  initial
  begin
    {nrst, regWrite, regRead, modeWave, counterClockOn, channelLineAPin, channelLineBPin} = '0;
    {channelLineADrive, channelLineBDrive, regAddr, regWdata, ev, compareRegC} = '0;
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(tcsirq_pkg::STATUS_OFF, 32'h0000_0000);
    rd(tcsirq_pkg::EN_VIEW_OFF, 32'h0000_0000);
    rd(tcsirq_pkg::EN_SET_OFF, 32'h0000_0000);
    rd(8'h00, 32'h0000_0000);
    @(posedge clk_sys);
    modeWave <= 1'b1;
    pulse(9'h0fd);
    rd(tcsirq_pkg::STATUS_OFF, 32'h0000_009d);
    rd(tcsirq_pkg::STATUS_OFF, 32'h0000_0000);
    @(posedge clk_sys);
    modeWave <= 1'b0;
    pulse(9'h0fd);
    rd(tcsirq_pkg::STATUS_OFF, 32'h0000_00f1);
    pulse(9'h102);
    pulse(9'h020);
    pulse(9'h020);
    rd(tcsirq_pkg::STATUS_OFF, 32'h0000_0022);
    rd(tcsirq_pkg::STATUS_OFF, 32'h0000_0000, 9'h001);
    rd(tcsirq_pkg::STATUS_OFF, 32'h0000_0001);
    pulse(9'h040);
    pulse(9'h040);
    rd(tcsirq_pkg::STATUS_OFF, 32'h0000_0042);
    wr(tcsirq_pkg::EN_SET_OFF, 32'hffff_ffff);
    wr(tcsirq_pkg::EN_CLR_OFF, 32'h0000_000f);
    rd(tcsirq_pkg::EN_VIEW_OFF, 32'h0000_00f0);
    pulse(9'h001);
    chk(irq, 32'h0);
    pulse(9'h080);
    chk(irq, 32'h1);
    wr(tcsirq_pkg::EN_CLR_OFF, 32'h0000_00ff);
    chk(irq, 32'h0);
    wr(tcsirq_pkg::EN_SET_OFF, 32'h0000_0001);
    rd(tcsirq_pkg::EN_VIEW_OFF, 32'h0000_0001);
    chk(irq, 32'h1);
    rd(tcsirq_pkg::STATUS_OFF, 32'h0000_0081);
    chk(irq, 32'h0);
    @(posedge clk_sys);
    counterClockOn <= 1'b1;
    channelLineAPin <= 1'b1;
    channelLineBDrive <= 1'b1;
    rd(tcsirq_pkg::STATUS_OFF, 32'h0003_0000);
    @(posedge clk_sys);
    modeWave <= 1'b1;
    rd(tcsirq_pkg::STATUS_OFF, 32'h0005_0000);
    @(posedge clk_sys);
    compareRegC <= 16'hbeef;
    rd(tcsirq_pkg::CMP_C_OFF, 32'h0000_beef);
    // Let the last checker attempts complete
    repeat (2) @(posedge clk_sys);
    finish_test();
  end
endmodule : tb
